// file: shared/ecpr_pkg.sv
// Constants for the ECP reverse-channel and EPP automatic port logic.
// Assumes a single 250 MHz clock; mode and control bits come from the port's register file.
package ecpr_pkg;

  // ----------------------------------------------------------------
  // Port modes
  // ----------------------------------------------------------------
  localparam logic [2:0] M_STD   = 3'h0;
  localparam logic [2:0] M_PS2   = 3'h1;
  localparam logic [2:0] M_PFIFO = 3'h2;
  localparam logic [2:0] M_ECP   = 3'h3;
  localparam logic [2:0] M_EPP   = 3'h4;
  localparam logic [2:0] M_TEST  = 3'h6;
  localparam logic [2:0] M_CFG   = 3'h7;

  // ----------------------------------------------------------------
  // Host FIFO port select
  // ----------------------------------------------------------------
  localparam logic [1:0] P_COMPAT = 2'h0;
  localparam logic [1:0] P_ADDR   = 2'h1;
  localparam logic [1:0] P_TEST   = 2'h2;

  // ----------------------------------------------------------------
  // FIFO and byte layout
  // ----------------------------------------------------------------
  localparam int         PD_W       = 8;
  localparam int         SYNC_W     = 11;
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam logic [4:0] FIFO_THR   = 5'h08;
  localparam int         CMD_BIT    = 7;
  localparam logic [7:0] RL_ONE     = 8'h01;

endpackage

// file: hw/ecpr_sync.sv
// Three-stage input synchroniser with agreement filter for parallel port pins.
// Assumes all inputs are asynchronous to clk_i; output changes once stages two and three agree.
`timescale 1ns/1ps
module ecpr_sync
  import ecpr_pkg::*;
#(
  parameter int W = SYNC_W
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  // Pins in, filtered levels out
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] lvl_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } ecpr_sync_t;

  ecpr_sync_t q, d;

  always_comb begin
    d    = q;
    d.s1 = pin_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.lvl[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lvl_o = q.lvl;

endmodule

// file: hw/ecpr_port.sv
// ECP backward reception with run-length expansion, EPP automatic cycles, FIFO test,
// configuration gate and interrupt event shaping for an IEEE 1284 port.
// Assumes register file, forward ECP engine and host decoding sit outside, on clk_i.
`timescale 1ns/1ps
module ecpr_port
  import ecpr_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  // Control bits
  input  wire logic [2:0]   mode_i,
  input  wire logic         dir_i,
  input  wire logic         ack_irq_en_i,
  input  wire logic         err_int_dis_i,
  input  wire logic         dma_en_i,
  input  wire logic         svc_int_i,
  input  wire logic         clk_frozen_i,
  // Host FIFO access
  input  wire logic         host_rd_i,
  input  wire logic         host_wr_i,
  input  wire logic [1:0]   host_port_i,
  input  wire logic [7:0]   host_wdata_i,
  input  wire logic         dma_ack_i,
  input  wire logic         tc_i,
  // Forward engine
  input  wire logic         fwd_pop_i,
  input  wire logic         fwd_busy_i,
  // EPP host strobes
  input  wire logic         epp_rd_i,
  input  wire logic         epp_wr_i,
  input  wire logic         epp_addr_i,
  input  wire logic         epp_data_wr_i,
  input  wire logic [7:0]   epp_wdata_i,
  // Pins in
  input  wire logic [7:0]   pd_i,
  input  wire logic         ack_n_i,
  input  wire logic         busy_i,
  input  wire logic         err_n_i,
  // Pins out
  output logic [7:0]        pd_o,
  output logic              pd_oe_o,
  output logic              afd_o,
  output logic              slin_o,
  output logic              stb_o,
  output logic              ctl_oe_o,
  // Status
  output logic [7:0]        fifo_rdata_o,
  output logic              fifo_full_o,
  output logic              fifo_empty_o,
  output logic              dma_req_o,
  output logic              irq_o,
  output logic              epp_busy_o,
  output logic [7:0]        epp_rdata_o,
  output logic              cfg_en_o
);

  // ----------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    R_IDLE  = 3'b000,
    R_REQ   = 3'b001,
    R_ACKD  = 3'b010,
    R_LATCH = 3'b011,
    R_EXP   = 3'b100
  } ecpr_rd_t;

  typedef enum logic [1:0] {
    E_IDLE = 2'b00,
    E_STRB = 2'b01,
    E_END  = 2'b10
  } ecpr_epp_t;

  typedef struct packed {
    logic [15:0][7:0] mem;
    logic [3:0]       wp;
    logic [3:0]       rp;
    logic [4:0]       cnt;
    ecpr_rd_t         rs;
    ecpr_epp_t        es;
    logic [2:0]       mode;
    logic [7:0]       byte_v;
    logic             busy_v;
    logic             rl_pend;
    logic [6:0]       run_length_count;
    logic [7:0]       rep;
    logic             epp_fwd;
    logic             l2;
    logic             l3;
    logic             l4;
    logic             ack_p;
    logic [7:0]       pd;
    logic             pd_oe;
    logic             afd;
    logic             slin;
    logic             stb;
    logic             ctl_oe;
    logic [7:0]       rdata;
    logic             full;
    logic             empty;
    logic             dma_req;
    logic             irq;
    logic [7:0]       epp_rdata;
    logic             cfg_en;
    logic             epp_busy;
  } ecpr_state_t;

  ecpr_state_t q, d;

  function automatic logic dma_mode(input logic [2:0] m);
    return (m == M_PFIFO) || (m == M_ECP);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] lvl;
  logic [7:0]        pd_s;
  logic              ack_s;
  logic              busy_s;
  logic              err_s;

  ecpr_sync #(.W(SYNC_W)) u_sync (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .pin_i  ({~err_n_i, busy_i, ~ack_n_i, pd_i}),
    .lvl_o  (lvl)
  );

  // Active-low pins pass inverted so the cleared stages read as idle, not as an edge
  assign pd_s   = lvl[7:0];
  assign ack_s  = ~lvl[8];
  assign busy_s = lvl[9];
  assign err_s  = ~lvl[10];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic       leave;
  logic       pop;
  logic       push;
  logic       epush;
  logic [7:0] wdat;
  logic [4:0] nc;
  logic [4:0] freeb;
  logic       lv2;
  logic       lv3;
  logic       lv4;

  always_comb begin
    d      = q;
    epush  = 1'b0;
    leave  = dma_mode(q.mode) && !dma_mode(mode_i);
    d.mode = mode_i;
    d.ack_p = ack_s;

    // Backward read engine
    case (q.rs)
      R_IDLE: begin
        // AFD stays low after a close: the peripheral may already be answering
        if (q.rl_pend && q.rep != 8'h00) begin
          d.rs = R_EXP;
        end else if (mode_i == M_ECP && dir_i && !q.full) begin
          d.afd = 1'b0;
          d.rs  = R_REQ;
        end
      end
      R_REQ: begin
        if (!ack_s) begin
          d.afd = 1'b1;
          d.rs  = R_ACKD;
        end
      end
      R_ACKD: begin
        if (ack_s) begin
          d.byte_v = pd_s;
          d.busy_v = busy_s;
          d.afd    = 1'b0;
          d.rs     = R_LATCH;
        end
      end
      R_LATCH: begin
        d.rs = R_IDLE;
        if (q.rl_pend) begin
          d.rep = {1'b0, q.run_length_count} + RL_ONE;
        end else if (q.busy_v) begin
          epush = 1'b1;
        end else if (!q.byte_v[CMD_BIT]) begin
          d.run_length_count     = q.byte_v[6:0];
          d.rl_pend = 1'b1;
        end
      end
      R_EXP: begin
        if (q.cnt != FIFO_DEPTH) begin
          epush = 1'b1;
          d.rep = q.rep - RL_ONE;
          if (q.rep == RL_ONE) begin
            d.rl_pend = 1'b0;
            d.rs      = R_IDLE;
          end
        end
      end
      default: d.rs = R_IDLE;
    endcase
    if (leave || mode_i == M_EPP) begin
      d.rs      = R_IDLE;
      d.rl_pend = 1'b0;
      d.rep     = 8'h00;
      d.afd     = 1'b1;
      epush     = 1'b0;
    end

    // FIFO access
    pop  = ((host_rd_i && host_port_i == P_TEST &&
            ((mode_i == M_ECP && dir_i) || mode_i == M_TEST)) ||
            (dma_ack_i && q.dma_req && dir_i) ||
            (fwd_pop_i && !dir_i && dma_mode(mode_i))) && q.cnt != 5'h00;
    push = (epush || (host_wr_i && ((mode_i == M_TEST && host_port_i == P_TEST) ||
            (dma_mode(mode_i) && !dir_i))) ||
            (dma_ack_i && q.dma_req && !dir_i)) && (q.cnt != FIFO_DEPTH || pop);
    wdat = epush ? q.byte_v : host_wdata_i;
    if (push) begin
      d.mem[q.wp] = wdat;
      d.wp        = q.wp + 4'h1;
    end
    if (pop) begin
      d.rdata = q.mem[q.rp];
      d.rp    = q.rp + 4'h1;
    end
    nc = q.cnt + {4'h0, push} - {4'h0, pop};
    if (mode_i == M_EPP) begin
      nc   = 5'h00;
      d.wp = 4'h0;
      d.rp = 4'h0;
    end
    d.cnt   = nc;
    d.full  = (nc == FIFO_DEPTH);
    d.empty = (nc == 5'h00) && !(dma_mode(mode_i) && !dir_i && fwd_busy_i);
    d.dma_req = dma_en_i && !svc_int_i && !leave &&
                ((mode_i == M_ECP && dir_i && nc != 5'h00) ||
                 (mode_i == M_TEST && (dir_i ? nc != 5'h00 : nc != FIFO_DEPTH)));

    // EPP automatic cycles
    case (q.es)
      E_IDLE: begin
        d.stb  = 1'b1;
        d.afd  = (mode_i == M_EPP) ? 1'b1 : d.afd;
        d.slin = 1'b1;
        if (mode_i == M_EPP && (epp_wr_i || epp_rd_i)) begin
          d.epp_fwd = epp_wr_i;
          d.stb     = !epp_wr_i;
          d.pd      = epp_wdata_i;
          d.afd     = epp_addr_i;
          d.slin    = !epp_addr_i;
          d.es      = E_STRB;
        end
      end
      E_STRB: begin
        d.afd = q.afd;
        if (epp_data_wr_i && q.epp_fwd) begin
          d.pd = epp_wdata_i;
        end
        if (busy_s) begin
          d.afd  = 1'b1;
          d.slin = 1'b1;
          d.es   = E_END;
        end
      end
      E_END: begin
        if (!busy_s) begin
          d.stb = 1'b1;
          d.es  = E_IDLE;
        end
      end
      default: d.es = E_IDLE;
    endcase
    if (mode_i != M_EPP) begin
      d.es = E_IDLE;
      d.stb = 1'b1;
      d.slin = 1'b1;
    end
    d.epp_rdata = pd_s;
    if (mode_i == M_TEST && !dir_i) begin
      d.pd = q.rdata;
    end
    case (mode_i)
      M_STD, M_PFIFO: d.pd_oe = 1'b1;
      M_EPP:          d.pd_oe = (d.es != E_IDLE) ? d.epp_fwd : !dir_i;
      default:        d.pd_oe = !dir_i;
    endcase
    d.ctl_oe = (mode_i != M_STD);
    d.cfg_en = (mode_i == M_CFG);
    d.epp_busy = (d.es != E_IDLE);

    // Interrupt events
    freeb = FIFO_DEPTH - q.cnt;
    lv2 = !svc_int_i && !dma_en_i && !dir_i && freeb >= FIFO_THR && !clk_frozen_i &&
          (dma_mode(mode_i) || mode_i == M_TEST);
    lv3 = !svc_int_i && !dma_en_i && dir_i && q.cnt >= FIFO_THR && !clk_frozen_i &&
          (mode_i == M_ECP || mode_i == M_TEST);
    lv4 = !err_int_dis_i && !err_s && !clk_frozen_i;
    d.l2 = lv2;
    d.l3 = lv3;
    d.l4 = lv4;
    d.irq = (lv2 && !q.l2) || (lv3 && !q.l3) || (lv4 && !q.l4) ||
            (!svc_int_i && dma_en_i && tc_i && dma_ack_i) ||
            (ack_irq_en_i && ack_s && !q.ack_p);
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      q       <= '0;
      q.afd   <= 1'b1;
      q.slin  <= 1'b1;
      q.stb   <= 1'b1;
      q.empty <= 1'b1;
      q.ack_p <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pd_o         = q.pd;
  assign pd_oe_o      = q.pd_oe;
  assign afd_o        = q.afd;
  assign slin_o       = q.slin;
  assign stb_o        = q.stb;
  assign ctl_oe_o     = q.ctl_oe;
  assign fifo_rdata_o = q.rdata;
  assign fifo_full_o  = q.full;
  assign fifo_empty_o = q.empty;
  assign dma_req_o    = q.dma_req;
  assign irq_o        = q.irq;
  assign epp_busy_o   = q.epp_busy;
  assign epp_rdata_o  = q.epp_rdata;
  assign cfg_en_o     = q.cfg_en;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_data_push;
    @(posedge clk_i) disable iff (srst_i)
    (q.rs == R_LATCH && !q.rl_pend && q.busy_v && !pop && mode_i == M_ECP)
      |=> (q.cnt == $past(q.cnt) + 5'h01);
  endproperty
  a_data_push: assert property (p_data_push) else $error("data byte not pushed");

  property p_cmd_drop;
    @(posedge clk_i) disable iff (srst_i)
    (q.rs == R_LATCH && !q.rl_pend && !q.busy_v && q.byte_v[CMD_BIT] && !pop)
      |=> (q.cnt == $past(q.cnt)) && !q.rl_pend;
  endproperty
  a_cmd_drop: assert property (p_cmd_drop) else $error("command byte not dropped");

  property p_exp_end;
    @(posedge clk_i) disable iff (srst_i)
    (q.rs == R_EXP && q.rep == RL_ONE && q.cnt != FIFO_DEPTH && mode_i == M_ECP)
      |=> (q.rs == R_IDLE) && !q.rl_pend;
  endproperty
  a_exp_end: assert property (p_exp_end) else $error("expansion did not end");

  property p_no_pop_addr;
    @(posedge clk_i) disable iff (srst_i)
    (host_rd_i && host_port_i != P_TEST && !dma_ack_i && !fwd_pop_i && mode_i == M_ECP)
      |=> (q.cnt >= $past(q.cnt));
  endproperty
  a_no_pop_addr: assert property (p_no_pop_addr) else $error("non-test read popped");

  property p_afd_start;
    @(posedge clk_i) disable iff (srst_i)
    $rose(q.rs == R_REQ) |-> !afd_o ##1 (afd_o || q.rs == R_REQ || q.rs == R_IDLE);
  endproperty
  a_afd_start: assert property (p_afd_start) else $error("read cycle not begun low");

  property p_afd_ackd;
    @(posedge clk_i) disable iff (srst_i)
    (q.rs == R_REQ && !ack_s && mode_i == M_ECP) |=> afd_o && q.rs == R_ACKD;
  endproperty
  a_afd_ackd: assert property (p_afd_ackd) else $error("AFD not raised on ACK");

  property p_leave;
    @(posedge clk_i) disable iff (srst_i)
    (dma_mode(q.mode) && !dma_mode(mode_i)) |=> !dma_req_o && !q.rl_pend;
  endproperty
  a_leave: assert property (p_leave) else $error("mode exit kept DMA or expansion");

  property p_epp_fifo;
    @(posedge clk_i) disable iff (srst_i)
    (mode_i == M_EPP) |=> fifo_empty_o && q.cnt == 5'h00 && !dma_req_o;
  endproperty
  a_epp_fifo: assert property (p_epp_fifo) else $error("FIFO live in EPP mode");

  property p_cfg;
    @(posedge clk_i) disable iff (srst_i)
    ##1 (cfg_en_o == ($past(mode_i) == M_CFG));
  endproperty
  a_cfg: assert property (p_cfg) else $error("config gate wrong");

  property p_epp_dir;
    @(posedge clk_i) disable iff (srst_i)
    (q.es == E_IDLE && mode_i == M_EPP && (epp_wr_i || epp_rd_i))
      |=> (pd_oe_o == $past(epp_wr_i));
  endproperty
  a_epp_dir: assert property (p_epp_dir) else $error("EPP direction not from strobe");

  property p_epp_hold;
    @(posedge clk_i) disable iff (srst_i)
    (q.es == E_STRB && !busy_s && mode_i == M_EPP)
      |=> ({afd_o, slin_o} == $past({afd_o, slin_o}));
  endproperty
  a_epp_hold: assert property (p_epp_hold) else $error("EPP strobe released early");

endmodule

// file: bench/ecpr_periph.sv
// Peripheral model: answers backward read cycles and EPP strobes.
// Assumes the bench resolves the data pins from the port's output enable.
`timescale 1ns/1ps
module ecpr_periph #(
  parameter logic [7:0] EPP_BYTE = 8'h3c
) (
  // Clock and mode
  input  wire logic       clk_i,
  input  wire logic       epp_i,
  // Strobes from the port
  input  wire logic       afd_i,
  input  wire logic       slin_i,
  // Pins driven
  output logic      [7:0] pd_o,
  output logic            busy_o,
  output logic            ack_n_o
);
  logic [8:0] q[$];
  int         dly = 1;

  initial begin
    pd_o    = 8'h5a;
    busy_o  = 1'b0;
    ack_n_o = 1'b1;
  end

  task automatic send(input logic [7:0] b, input logic bz);
    q.push_back({bz, b});
  endtask

  task automatic step();
    @(posedge clk_i);
    #1;
  endtask

  task automatic ack_pulse();
    ack_n_o = 1'b0;
    repeat (8) step();
    ack_n_o = 1'b1;
  endtask

  // ----------
  // Responder, prompt and slow in turn
  // ----------
  always begin
    step();
    if (epp_i && !(afd_i && slin_i)) begin
      pd_o = EPP_BYTE;
      repeat (dly) step();
      busy_o = 1'b1;
      while (!(afd_i && slin_i)) step();
      repeat (dly) step();
      busy_o = 1'b0;
      pd_o   = ~pd_o;
      dly    = 8 - dly;
    end else if (!epp_i && !afd_i && q.size() > 0) begin
      {busy_o, pd_o} = q.pop_front();
      repeat (dly) step();
      ack_n_o = 1'b0;
      while (!afd_i) step();
      ack_n_o = 1'b1;
      while (afd_i) step();
      {busy_o, pd_o} = ~{busy_o, pd_o};
      dly = 8 - dly;
    end
  end
endmodule

// file: bench/ecpr_port_bench.sv
// Self-checking bench: backward reception, EPP cycles, FIFO test and events.
// Assumes ecpr_periph stands on the pins as the far-side peripheral.
`timescale 1ns/1ps
module ecpr_port_bench;
  import ecpr_pkg::*;

  localparam logic [7:0] RD_BYTE = 8'h3c;

  logic       clk_i, srst_i, dir_i, ack_irq_en_i, err_int_dis_i, dma_en_i, svc_int_i;
  logic       clk_frozen_i, host_rd_i, host_wr_i, dma_ack_i, tc_i, epp_rd_i, epp_wr_i;
  logic       epp_addr_i, epp_data_wr_i, err_n_i, per_busy, per_ack_n, pd_oe_o, afd_o;
  logic       slin_o, stb_o, fifo_full_o, fifo_empty_o, dma_req_o, irq_o, epp_busy_o;
  logic       cfg_en_o, ctl_oe_o, fwd_pop_i, fwd_busy_i;
  logic [1:0] host_port_i;
  logic [2:0] mode_i;
  logic [7:0] host_wdata_i, epp_wdata_i, pd_i, per_pd, pd_o, fifo_rdata_o, epp_rdata_o, b;
  logic [7:0] q[$];
  int         failures = 0, n_compared = 0, n_irq = 0, run_length_count = -1, t0 = 0, i, k;

  assign pd_i = pd_oe_o ? pd_o : per_pd;

  ecpr_port DUT (
    .clk_i, .srst_i, .mode_i, .dir_i, .ack_irq_en_i, .err_int_dis_i, .dma_en_i, .svc_int_i,
    .clk_frozen_i, .host_rd_i, .host_wr_i, .host_port_i, .host_wdata_i, .dma_ack_i, .tc_i,
    .fwd_pop_i, .fwd_busy_i, .epp_rd_i, .epp_wr_i, .epp_addr_i, .epp_data_wr_i,
    .epp_wdata_i, .pd_i, .ack_n_i(per_ack_n), .busy_i(per_busy), .err_n_i, .pd_o, .pd_oe_o,
    .afd_o, .slin_o, .stb_o, .ctl_oe_o, .fifo_rdata_o, .fifo_full_o, .fifo_empty_o,
    .dma_req_o, .irq_o, .epp_busy_o, .epp_rdata_o, .cfg_en_o
  );

  ecpr_periph #(.EPP_BYTE(RD_BYTE)) PER (
    .clk_i, .epp_i(mode_i == M_EPP), .afd_i(afd_o), .slin_i(slin_o), .pd_o(per_pd),
    .busy_o(per_busy), .ack_n_o(per_ack_n)
  );

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  always @(posedge clk_i) if (irq_o === 1'b1) n_irq <= n_irq + 1;

  // ----------
  // Tasks
  // ----------
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic print_verdict();
    if (failures == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Reference model of the backward byte stream
  task automatic feed(input logic [7:0] d, input logic bz);
    PER.send(d, bz);
    if (run_length_count >= 0) begin
      repeat (run_length_count + 1) q.push_back(d);
      run_length_count = -1;
    end else if (bz) q.push_back(d);
    else if (!d[CMD_BIT]) run_length_count = d;
  endtask

  task automatic rd(input logic [1:0] p, input logic pop);
    int n;
    for (n = 0; n < 400 && fifo_empty_o !== 1'b0; n++) tick();
    host_port_i = p;
    host_rd_i = 1'b1;
    tick();
    host_rd_i = 1'b0;
    tick();
    if (pop) chk("fifo_rdata", q.pop_front(), fifo_rdata_o);
  endtask

  task automatic wr(input logic [7:0] d);
    host_port_i = P_TEST;
    host_wdata_i = d;
    host_wr_i = 1'b1;
    tick();
    host_wr_i = 1'b0;
    tick();
  endtask

  task automatic irqs(input int d);
    repeat (10) tick();
    chk("irq_count", 8'(t0 + d), 8'(n_irq));
    t0 = n_irq;
  endtask

  // ----------
  // Tests
  // ----------
  initial begin
    {srst_i, err_n_i, svc_int_i, err_int_dis_i} = 4'hf;
    {dir_i, ack_irq_en_i, dma_en_i, clk_frozen_i, host_rd_i, host_wr_i} = 6'h00;
    {dma_ack_i, tc_i, epp_rd_i, epp_wr_i, epp_addr_i, epp_data_wr_i} = 6'h00;
    {fwd_pop_i, fwd_busy_i} = 2'h0;
    {mode_i, host_port_i, host_wdata_i, epp_wdata_i} = 21'h0;
    b = 8'($urandom(32'h8796));
    repeat (12) tick();
    srst_i = 1'b0;
    repeat (4) tick();
    for (i = 0; i < 8; i++) begin
      mode_i = 3'(i);
      repeat (2) tick();
      chk("cfg_en", 8'(i == 7), 8'(cfg_en_o));
      chk("ctl_oe", 8'(i != 0), 8'(ctl_oe_o));
    end
    mode_i = M_ECP;
    dir_i = 1'b1;
    feed(8'h85, 1'b0);
    feed(8'($urandom), 1'b1);
    feed(8'h02, 1'b0);
    feed(8'($urandom), 1'b0);
    feed(8'h7f, 1'b0);
    feed(8'($urandom), 1'b1);
    for (k = 0; k < 3000 && fifo_full_o !== 1'b1; k++) tick();
    chk("fifo_full", 8'h01, 8'(fifo_full_o));
    rd(P_COMPAT, 1'b0);
    rd(P_ADDR, 1'b0);
    chk("full_kept", 8'h01, 8'(fifo_full_o));
    while (q.size() > 0) rd(P_TEST, 1'b1);
    repeat (3) tick();
    chk("fifo_empty", 8'h01, 8'(fifo_empty_o));
    chk("afd_start", 8'h00, 8'(afd_o));
    dma_en_i = 1'b1;
    svc_int_i = 1'b0;
    t0 = n_irq;
    for (i = 0; i < 3; i++) feed(8'($urandom), 1'b1);
    for (i = 0; i < 3; i++) begin
      for (k = 0; k < 400 && dma_req_o !== 1'b1; k++) tick();
      tc_i = (i == 2);
      dma_ack_i = 1'b1;
      tick();
      dma_ack_i = 1'b0;
      tc_i = 1'b0;
      tick();
      chk("dma_rdata", q.pop_front(), fifo_rdata_o);
    end
    irqs(1);
    chk("dma_req_idle", 8'h00, 8'(dma_req_o));
    feed(8'h1f, 1'b0);
    feed(8'($urandom), 1'b1);
    for (k = 0; k < 3000 && fifo_full_o !== 1'b1; k++) tick();
    chk("dma_req", 8'h01, 8'(dma_req_o));
    mode_i = M_EPP;
    repeat (2) tick();
    chk("dma_req_cut", 8'h00, 8'(dma_req_o));
    chk("epp_fifo", 8'h01, 8'(fifo_empty_o));
    q.delete();
    for (i = 0; i < 4; i++) begin
      dir_i = i[0];
      epp_addr_i = i[1];
      epp_wdata_i = 8'($urandom);
      epp_wr_i = i[0];
      epp_rd_i = !i[0];
      tick();
      epp_wr_i = 1'b0;
      epp_rd_i = 1'b0;
      chk("epp_stb", 8'(!i[0]), 8'(stb_o));
      chk("epp_busy", 8'h01, 8'(epp_busy_o));
      chk("epp_pd_oe", 8'(i[0]), 8'(pd_oe_o));
      chk("epp_strobe", 8'({!i[1], i[1]}), 8'({slin_o, afd_o}));
      if (i[0]) begin
        b = 8'($urandom);
        epp_wdata_i = b;
        epp_data_wr_i = 1'b1;
        tick();
        epp_data_wr_i = 1'b0;
        chk("epp_pd", b, pd_o);
      end
      for (k = 0; k < 400 && {afd_o, slin_o} !== 2'b11; k++) tick();
      if (!i[0]) chk("epp_rdata", RD_BYTE, epp_rdata_o);
      for (k = 0; k < 400 && epp_busy_o !== 1'b0; k++) tick();
      tick();
    end
    {dma_en_i, clk_frozen_i, dir_i} = 3'h3;
    mode_i = M_TEST;
    repeat (2) tick();
    t0 = n_irq;
    for (i = 0; i < 17; i++) begin
      b = 8'($urandom);
      if (i < 16) q.push_back(b);
      wr(b);
    end
    chk("test_full", 8'h01, 8'(fifo_full_o));
    irqs(0);
    clk_frozen_i = 1'b0;
    irqs(1);
    dir_i = 1'b0;
    while (q.size() > 0) rd(P_TEST, 1'b1);
    irqs(1);
    svc_int_i = 1'b1;
    tick();
    svc_int_i = 1'b0;
    irqs(1);
    svc_int_i = 1'b1;
    mode_i = M_STD;
    irqs(0);
    err_int_dis_i = 1'b0;
    err_n_i = 1'b0;
    irqs(1);
    err_n_i = 1'b1;
    err_int_dis_i = 1'b1;
    irqs(0);
    err_n_i = 1'b0;
    irqs(0);
    err_int_dis_i = 1'b0;
    irqs(1);
    err_n_i = 1'b1;
    ack_irq_en_i = 1'b1;
    PER.ack_pulse();
    irqs(1);
    ack_irq_en_i = 1'b0;
    PER.ack_pulse();
    irqs(0);
    mode_i = M_PFIFO;
    fwd_busy_i = 1'b1;
    wr(8'($urandom));
    fwd_pop_i = 1'b1;
    tick();
    fwd_pop_i = 1'b0;
    tick();
    chk("fwd_empty_busy", 8'h00, 8'(fifo_empty_o));
    fwd_busy_i = 1'b0;
    repeat (2) tick();
    chk("fwd_empty_done", 8'h01, 8'(fifo_empty_o));
    print_verdict();
  end

  initial begin
    repeat (30000) @(posedge clk_i);
    failures++;
    print_verdict();
  end
endmodule
